// *** adc_cfg_consts.svh ***
// register indices, field positions, reset values and span scale constants
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

`define IDX_AVG_CTRL 8'h27
`define IDX_GAIN_RANGING 8'h28
`define IDX_POWER_DOWN 8'h29
`define IDX_CH0_RANGE 8'h2A
`define IDX_AVG_STATUS 8'h40

`define AVG_EN_BIT 7
`define AVG_CODE_MSB 3
`define RST_AVG_EN 1'h0
`define RST_AVG_CODE 4'h0
`define RST_GAIN_RANGING 4'hF
`define RST_POWER_DOWN 4'h0
`define RST_CH0_RANGE 4'hF

`define FS_MV_2V5 16'h09C4
`define FS_MV_5V 16'h1388
`define FS_MV_6V25 16'h186A
`define FS_MV_10V 16'h2710
`define FS_MV_12V5 16'h30D4
`define FS_MV_20V 16'h4E20
`define FS_MV_25V 16'h61A8
`define FS_MV_40V 16'h9C40

`endif

// *** adc_cfg_pkg.sv ***
// shared types of the channel configuration block
package adc_cfg_pkg;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } chan_out_s;

  typedef struct packed {
    logic bipolar;
    logic [15:0] full_scale_mv;
  } range_s;

  typedef logic [3:0][15:0] chan_data_t;
  typedef chan_out_s [3:0] chan_out_t;
endpackage : adc_cfg_pkg

// *** input_range_decode.sv ***
// decodes a four-bit input range code into polarity and full scale
`timescale 1ns/100ps
`include "adc_cfg_consts.svh"
module input_range_decode (
  input wire logic [3:0] code,
  output adc_cfg_pkg::range_s range
);
  import adc_cfg_pkg::*;

  logic [15:0] fs_mv;

  always_comb begin
    case (code[3:1])
      3'h0: fs_mv = `FS_MV_2V5;
      3'h1: fs_mv = `FS_MV_5V;
      3'h2: fs_mv = `FS_MV_6V25;
      3'h3: fs_mv = `FS_MV_10V;
      3'h4: fs_mv = `FS_MV_12V5;
      3'h5: fs_mv = `FS_MV_20V;
      3'h6: fs_mv = `FS_MV_25V;
      default: fs_mv = `FS_MV_40V;
    endcase
  end

  assign range.bipolar = code[0];
  assign range.full_scale_mv = fs_mv;
endmodule : input_range_decode

// *** channel_averager.sv ***
// per-channel sample pass-through or power-of-two averaging
`timescale 1ns/100ps
module channel_averager (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic avg_en,
  input wire logic [3:0] code,
  input wire logic take,
  input wire logic [15:0] sample,
  output adc_cfg_pkg::chan_out_s result,
  output logic busy
);
  import adc_cfg_pkg::*;

  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic signed [31:0] sum_q;
  logic signed [31:0] sum_d;
  chan_out_s res_q;
  chan_out_s res_d;
  logic [16:0] target;
  logic [4:0] shift;
  logic signed [31:0] acc;
  logic signed [31:0] avg;
  logic last;

  // count is two to code plus one
  assign shift = {1'b0, code} + 5'h01;
  assign target = 17'h00001 << shift;
  assign acc = sum_q + {{16{sample[15]}}, sample};
  assign avg = acc >>> shift;
  assign last = (cnt_q + 17'h00001) == target;

  always_comb begin
    cnt_d = cnt_q;
    sum_d = sum_q;
    res_d = '{valid: 1'b0, data: res_q.data};
    if (!avg_en) begin
      cnt_d = '0;
      sum_d = '0;
      if (take) begin
        res_d = '{valid: 1'b1, data: sample};
      end
    end else if (take) begin
      if (last) begin
        cnt_d = '0;
        sum_d = '0;
        res_d = '{valid: 1'b1, data: avg[15:0]};
      end else begin
        cnt_d = cnt_q + 17'h00001;
        sum_d = acc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      sum_q <= '0;
      res_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      res_q <= res_d;
    end
  end

  assign result = res_q;
  assign busy = cnt_q != 17'h00000;
endmodule : channel_averager

// *** adc_channel_mode_config.sv ***
// apb register file and datapath control for averaging, gain ranging, sleep and range
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "adc_cfg_consts.svh"

// What this block does
// - Bit 7 of the averaging control register turns averaging on when 1 and off when 0, resetting to 0.
// - With averaging on, each channel averages 2 to the power of (ratio code plus one) results.
// - Bits 0 to 3 of the gain-ranging register enable automatic gain ranging per channel, all resetting to 1.
// - A channel whose power-down bit is 1 ignores every conversion request, and all bits reset to 0.
// - The low four bits of the channel 0 range register pick its input range, resetting to 0xF.
// - Even range codes are unipolar and odd bipolar, pairs stepping from 2.5 V up to 40 V.
module adc_channel_mode_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_req,
  input wire adc_cfg_pkg::chan_data_t conv_data,
  output adc_cfg_pkg::chan_out_t chan_result,
  output logic [3:0] chan_taken,
  output logic [3:0] automatic_gain_ranging,
  output logic [3:0] chan_power_down,
  output logic averaging_enable,
  output logic [3:0] averaging_count_code,
  output logic [3:0] chan0_input_range_code,
  output adc_cfg_pkg::range_s chan0_range
);
  import adc_cfg_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic avg_en_q;
  logic [3:0] avg_code_q;
  logic [3:0] gain_rng_q;
  logic [3:0] pwr_down_q;
  logic [3:0] range_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  range_s range_q2;
  range_s range_dec;
  logic [3:0] busy;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup;
  logic access;
  logic wr;
  logic aligned;
  logic [9:0] idx;
  logic hit_avg;
  logic hit_gain;
  logic hit_pwr;
  logic hit_range;
  logic hit_stat;
  logic mapped;
  logic ro_write;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign aligned = paddr[1:0] == 2'h0;
  assign idx = paddr[11:2];
  assign hit_avg = aligned && idx == {2'h0, `IDX_AVG_CTRL};
  assign hit_gain = aligned && idx == {2'h0, `IDX_GAIN_RANGING};
  assign hit_pwr = aligned && idx == {2'h0, `IDX_POWER_DOWN};
  assign hit_range = aligned && idx == {2'h0, `IDX_CH0_RANGE};
  assign hit_stat = aligned && idx == {2'h0, `IDX_AVG_STATUS};
  assign mapped = hit_avg || hit_gain || hit_pwr || hit_range || hit_stat;
  // status is read-only: a write there is flagged, not stored
  assign ro_write = hit_stat && pwrite;

  // zero wait states keep the slave simple; data is staged in setup
  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    prdata_d = 32'h00000000;
    if (hit_avg) begin
      prdata_d[`AVG_EN_BIT] = avg_en_q;
      prdata_d[`AVG_CODE_MSB:0] = avg_code_q;
    end else if (hit_gain) begin
      prdata_d[3:0] = gain_rng_q;
    end else if (hit_pwr) begin
      prdata_d[3:0] = pwr_down_q;
    end else if (hit_range) begin
      prdata_d[3:0] = range_q;
    end else if (hit_stat) begin
      prdata_d[3:0] = busy;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h00000000 : prdata_d;
      pslverr_q <= !mapped || ro_write;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = access && pslverr_q;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_en_q <= `RST_AVG_EN;
      avg_code_q <= `RST_AVG_CODE;
      gain_rng_q <= `RST_GAIN_RANGING;
      pwr_down_q <= `RST_POWER_DOWN;
      range_q <= `RST_CH0_RANGE;
    end else if (wr) begin
      if (hit_avg) begin
        avg_en_q <= pwdata[`AVG_EN_BIT];
        // ratio written while disabled is trusted
        avg_code_q <= pwdata[`AVG_CODE_MSB:0];
      end
      if (hit_gain) begin
        gain_rng_q <= pwdata[3:0];
      end
      if (hit_pwr) begin
        pwr_down_q <= pwdata[3:0];
      end
      if (hit_range) begin
        range_q <= pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion datapath
  // ---------------------------------------------------------------
  logic [3:0] take;

  assign take = {4{conv_req}} & ~pwr_down_q;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      channel_averager u_avg (
        .pclk(pclk),
        .presetn(presetn),
        .avg_en(avg_en_q),
        .code(avg_code_q),
        .take(take[ch]),
        .sample(conv_data[ch]),
        .result(chan_result[ch]),
        .busy(busy[ch])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // range decode, registered so the outputs come from flops
  // ---------------------------------------------------------------
  input_range_decode u_range (
    .code(range_q),
    .range(range_dec)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset code decodes to 40 V bipolar
      range_q2 <= '{bipolar: 1'b1, full_scale_mv: `FS_MV_40V};
    end else begin
      range_q2 <= range_dec;
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  assign chan_taken = take;
  assign automatic_gain_ranging = gain_rng_q;
  assign chan_power_down = pwr_down_q;
  assign averaging_enable = avg_en_q;
  assign averaging_count_code = avg_code_q;
  // range code to the front end
  assign chan0_input_range_code = range_q;
  assign chan0_range = range_q2;
endmodule : adc_channel_mode_config

// *** adc_channel_mode_config_props.sv ***
// assertion checker for the channel configuration block
`timescale 1ns/100ps
module adc_channel_mode_config_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic conv_req,
  input wire adc_cfg_pkg::chan_out_t chan_result,
  input wire logic [3:0] chan_taken,
  input wire logic [3:0] automatic_gain_ranging,
  input wire logic [3:0] chan_power_down,
  input wire logic averaging_enable,
  input wire logic [3:0] chan0_input_range_code,
  input wire adc_cfg_pkg::range_s chan0_range
);
  import adc_cfg_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ready is tied high, so a write lands at its first access edge
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  AST_AVG_EN:
    assert property (s_wr(12'h09C) |=> averaging_enable == $past(pwdata[7])) else $error("enable lost");
  AST_GAIN:
    assert property (s_wr(12'h0A0) |=> automatic_gain_ranging == $past(pwdata[3:0])) else $error("gain lost");
  AST_SLEEP:
    assert property (s_wr(12'h0A4) |=> chan_power_down == $past(pwdata[3:0])) else $error("sleep lost");
  AST_TAKEN:
    assert property (chan_taken == ({4{conv_req}} & ~chan_power_down)) else $error("take mask");
  AST_ASLEEP:
    assert property (chan_power_down[1] |=> !chan_result[1].valid) else $error("sleeper answered");
  AST_PASS:
    assert property (conv_req && !averaging_enable && !chan_power_down[0] |=> chan_result[0].valid)
      else $error("no result");
  AST_BIPOLAR:
    assert property (1'b1 |=> chan0_range.bipolar == $past(chan0_input_range_code[0])) else $error("polarity");
  AST_RANGE_CODE:
    assert property (s_wr(12'h0A8) |=> chan0_input_range_code == $past(pwdata[3:0])) else $error("range lost");
endmodule : adc_channel_mode_config_props
bind adc_channel_mode_config adc_channel_mode_config_props i_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .conv_req(conv_req),
  .chan_result(chan_result),
  .chan_taken(chan_taken),
  .automatic_gain_ranging(automatic_gain_ranging),
  .chan_power_down(chan_power_down),
  .averaging_enable(averaging_enable),
  .chan0_input_range_code(chan0_input_range_code),
  .chan0_range(chan0_range)
);

// *** adc_channel_mode_config_tb.sv ***
// bench for the channel configuration block
`timescale 1ns/100ps
module adc_channel_mode_config_tb;
  import adc_cfg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_req = 1'b0;
  logic pready, pslverr, averaging_enable, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  chan_data_t conv_data = 64'h0;
  chan_out_t chan_result;
  range_s chan0_range;
  logic [3:0] chan_taken, automatic_gain_ranging, chan_power_down, averaging_count_code, chan0_input_range_code, ev;
  logic [15:0] ed [4];
  logic [15:0] fs [8] = '{16'h09C4, 16'h1388, 16'h186A, 16'h2710, 16'h30D4, 16'h4E20, 16'h61A8, 16'h9C40};
  int n_errors = 0, n_compared = 0, cyc = 0, sum [4], cnt [4];
  always #50 pclk = ~pclk;
  adc_channel_mode_config i_adc_channel_mode_config (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .conv_req(conv_req),
    .conv_data(conv_data),
    .chan_result(chan_result),
    .chan_taken(chan_taken),
    .automatic_gain_ranging(automatic_gain_ranging),
    .chan_power_down(chan_power_down),
    .averaging_enable(averaging_enable),
    .averaging_count_code(averaging_count_code),
    .chan0_input_range_code(chan0_input_range_code),
    .chan0_range(chan0_range)
  );
  always @(posedge pclk) begin
    if (++cyc == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  task stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // random burst; the model runs one cycle ahead of the compare
  task run(input int n, input logic [3:0] m, input logic av, input int k);
    logic r;
    chan_data_t d;
    ev = 4'h0;
    sum = '{4{0}};
    cnt = '{4{0}};
    for (int i = 0; i <= n; i++) begin
      r = (i < n) ? 1'($urandom) : 1'b0;
      d = {$urandom, $urandom};
      @(posedge pclk);
      conv_req <= r;
      conv_data <= d;
      @(negedge pclk);
      chk("taken", chan_taken, {4{r}} & ~m);
      for (int c = 0; c < 4; c++) begin
        chk("valid", chan_result[c].valid, ev[c]);
        if (ev[c]) chk("data", chan_result[c].data, ed[c]);
        if (r && !m[c]) begin
          sum[c] += $signed(d[c]);
          cnt[c]++;
        end
        ev[c] = r && !m[c] && (!av || cnt[c] == 1 << k);
        ed[c] = av ? 16'(sum[c] >>> k) : d[c];
        if (ev[c]) begin
          sum[c] = 0;
          cnt[c] = 0;
        end
      end
    end
  endtask : run
  initial begin
    void'($urandom(45));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset levels", {automatic_gain_ranging, chan_power_down, averaging_enable, averaging_count_code,
      chan0_input_range_code}, {4'hF, 4'h0, 1'b0, 4'h0, 4'hF});
    chk("reset range", chan0_range, {1'b1, fs[7]});
    for (logic [11:0] a = 12'h09C; a < 12'h0AC; a += 12'h4) begin
      apb(1'b0, a, 32'h0);
      chk("reset", rd, a[2] ? 32'h0 : 32'hF);
      apb(1'b1, a, 32'hFFFFFF7F);
      apb(1'b0, a, 32'h0);
      chk("reserved", {er, rd[30:0]}, 32'hF);
    end
    @(negedge pclk);
    chk("levels", {automatic_gain_ranging, chan_power_down, averaging_enable, averaging_count_code,
      chan0_input_range_code}, {4'hF, 4'hF, 1'b0, 4'hF, 4'hF});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(1'b0, 12'h0A1, 32'h0);
    chk("unaligned", {er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h100, 32'hF);
    chk("status write", {er, rd[30:0]}, 32'h80000000);
    for (int j = 0; j < 16; j++) begin
      apb(1'b1, 12'h0A8, j);
      @(negedge pclk);
      @(negedge pclk);
      chk("range", chan0_range, {j[0], fs[j >> 1]});
    end
    for (int j = 0; j < 7; j++) begin
      w = (j == 0) ? 32'hF : $urandom;
      // averaging cleared before a new code
      apb(1'b1, 12'h09C, 32'h0);
      apb(1'b1, 12'h0A4, w);
      apb(1'b1, 12'h09C, (j > 2) ? 32'h7D + j : 32'h0);
      run((j > 2) ? 6 << (j - 2) : 20, w[3:0], j > 2, j - 2);
      apb(1'b0, 12'h100, 32'h0);
      chk("status", rd, {28'h0, cnt[3] != 0, cnt[2] != 0, cnt[1] != 0, cnt[0] != 0});
    end
    stop_test;
  end
endmodule : adc_channel_mode_config_tb
